// [inc/emb_pkg.sv]
// Package for the external memory and I/O bus interface: widths, encodings and carriers.
package emb_pkg;

    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ADDR_W       = 24;
    localparam int unsigned RST_MIN_CYC  = 3;
    // Edges an access stays open before it may end: strobe register plus two data synchroniser stages
    localparam int unsigned ACC_MIN_CYC  = 3;
    // Idle level of every active-low strobe
    localparam logic        STROBE_IDLE  = 1'b1;

    typedef enum logic [1:0]
    {
        EMB_KIND_READ  = 2'h0,
        EMB_KIND_WRITE = 2'h1,
        EMB_KIND_FETCH = 2'h2
    } emb_kind_t;

    typedef enum logic [1:0]
    {
        EMB_ST_IDLE   = 2'h0,
        EMB_ST_ACCESS = 2'h1,
        EMB_ST_FINISH = 2'h3,
        EMB_ST_HELD   = 2'h2
    } emb_state_t;

    // Access request from the core side
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        emb_kind_t         kind;
        logic              io_space;
    } emb_req_t;

    // Control strobes toward the pins, all active low
    typedef struct packed
    {
        logic mem_request_n;
        logic io_request_n;
        logic read_strobe_n;
        logic store_strobe_n;
        logic fetch_indicator_n;
    } emb_ctrl_t;

    localparam emb_ctrl_t CTRL_IDLE = '{STROBE_IDLE, STROBE_IDLE, STROBE_IDLE, STROBE_IDLE, STROBE_IDLE};

endpackage

// [verilog/emb_bus_master.sv]
// External memory and I/O bus master with wait stretching and bus hold release.
`timescale 1ns/100ps
`default_nettype none
module emb_bus_master
    import emb_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              req_valid_i,
    input  wire emb_req_t          req_i,
    output logic                   req_ready_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   held_o,
    output logic [ADDR_W-1:0]      ext_addr_i_o,
    input  wire logic              wait_n_i,
    input  wire logic              bus_hold_request_n_i,
    output logic                   bus_hold_grant_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   addr_oe_o,
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    input  wire logic              mem_request_n_i,
    input  wire logic              io_request_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    output emb_ctrl_t              ctrl_o,
    output logic                   ctrl_oe_o,
    output logic                   req_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic              wait_s1_r;
    logic              wait_s2_r;
    logic              hreq_s1_r;
    logic              hreq_s2_r;
    logic [DATA_W-1:0] data_s1_r;
    logic [DATA_W-1:0] data_s2_r;
    logic [ADDR_W-1:0] xaddr_s1_r;
    logic [ADDR_W-1:0] xaddr_s2_r;
    logic              xmreq_s1_r;
    logic              xioreq_s1_r;
    logic              xmreq_s2_r;
    logic              xioreq_s2_r;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wait_s1_r   <= 1'b1;
            wait_s2_r   <= 1'b1;
            hreq_s1_r   <= 1'b1;
            hreq_s2_r   <= 1'b1;
            data_s1_r   <= '0;
            data_s2_r   <= '0;
            xaddr_s1_r  <= '0;
            xaddr_s2_r  <= '0;
            xmreq_s1_r  <= 1'b1;
            xioreq_s1_r <= 1'b1;
            xmreq_s2_r  <= 1'b1;
            xioreq_s2_r <= 1'b1;
        end
        else
        begin
            wait_s1_r   <= wait_n_i;
            wait_s2_r   <= wait_s1_r;
            hreq_s1_r   <= bus_hold_request_n_i;
            hreq_s2_r   <= hreq_s1_r;
            data_s1_r   <= data_i;
            data_s2_r   <= data_s1_r;
            xaddr_s1_r  <= addr_i;
            xaddr_s2_r  <= xaddr_s1_r;
            xmreq_s1_r  <= mem_request_n_i;
            xioreq_s1_r <= io_request_n_i;
            xmreq_s2_r  <= xmreq_s1_r;
            xioreq_s2_r <= xioreq_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    emb_state_t state_r;
    emb_req_t   cur_r;
    logic [1:0] acc_cnt_r;
    logic       acc_full;

    // Read data must clear its synchroniser before the access may close, whatever wait says
    assign acc_full = (acc_cnt_r == 2'(ACC_MIN_CYC));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r   <= EMB_ST_IDLE;
            cur_r     <= '0;
            acc_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                EMB_ST_IDLE:
                    if (!hreq_s2_r)
                        state_r <= EMB_ST_HELD;
                    else if (req_valid_i)
                    begin
                        state_r <= EMB_ST_ACCESS;
                        cur_r     <= req_i;
                        acc_cnt_r <= '0;
                    end
                EMB_ST_ACCESS:
                begin
                    if (!acc_full)
                        acc_cnt_r <= acc_cnt_r + 2'h1;
                    if (wait_s2_r && acc_full)
                        state_r <= EMB_ST_FINISH;
                end
                EMB_ST_FINISH:
                    state_r <= EMB_ST_IDLE;
                EMB_ST_HELD:
                    if (hreq_s2_r)
                        state_r <= EMB_ST_IDLE;
                default:
                    state_r <= EMB_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered

    emb_ctrl_t ctrl_nxt;
    logic      in_access;

    logic      bus_own;
    logic      acc_end;

    assign in_access = (state_r == EMB_ST_ACCESS);
    assign acc_end   = in_access && wait_s2_r && acc_full;
    // A hold request only takes the pins once the sequencer is idle, never in mid-access
    assign bus_own   = (state_r != EMB_ST_HELD) && !((state_r == EMB_ST_IDLE) && !hreq_s2_r);

    always_comb
    begin
        ctrl_nxt = CTRL_IDLE;
        if (in_access)
        begin
            ctrl_nxt.io_request_n      = !cur_r.io_space;
            ctrl_nxt.mem_request_n     = cur_r.io_space;
            ctrl_nxt.read_strobe_n     = (cur_r.kind == EMB_KIND_WRITE);
            ctrl_nxt.store_strobe_n    = (cur_r.kind != EMB_KIND_WRITE);
            ctrl_nxt.fetch_indicator_n = !((cur_r.kind == EMB_KIND_FETCH) && !cur_r.io_space);
        end
    end

    // Strobes lag the state by one cycle, so ACCESS exit leaves them low one more edge; FINISH clears them.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_o             <= CTRL_IDLE;
            req_oe_o           <= 1'b0;
            ctrl_oe_o          <= 1'b0;
            addr_oe_o          <= 1'b0;
            addr_o             <= '0;
            data_o             <= '0;
            data_oe_o          <= 1'b0;
            bus_hold_grant_n_o <= 1'b1;
            held_o             <= 1'b0;
        end
        else
        begin
            ctrl_o    <= ctrl_nxt;
            req_oe_o  <= bus_own;
            ctrl_oe_o <= bus_own;
            addr_oe_o <= bus_own;
            addr_o    <= cur_r.addr;
            data_o    <= cur_r.wdata;
            data_oe_o <= in_access && (cur_r.kind == EMB_KIND_WRITE);
            bus_hold_grant_n_o <= !(state_r == EMB_ST_HELD);
            held_o    <= (state_r == EMB_ST_HELD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core side answers

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            req_ready_o  <= 1'b0;
            done_o       <= 1'b0;
            rdata_o      <= '0;
            ext_addr_i_o <= '0;
        end
        else
        begin
            req_ready_o <= (state_r == EMB_ST_IDLE) && hreq_s2_r && !req_valid_i;
            done_o      <= acc_end;
            if (acc_end && (cur_r.kind != EMB_KIND_WRITE))
                rdata_o <= data_s2_r;
            if ((state_r == EMB_ST_HELD) && !(xmreq_s2_r && xioreq_s2_r))
                ext_addr_i_o <= xaddr_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_data_write_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        data_oe_o |-> (!ctrl_o.store_strobe_n && ctrl_oe_o))
        else $error("data driven outside write");
    a_io_dir_strobe: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_o.io_request_n |-> (ctrl_o.read_strobe_n != ctrl_o.store_strobe_n))
        else $error("io request without single direction");
    a_io_held_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !bus_hold_grant_n_o |-> !req_oe_o)
        else $error("io request driven while held");
    a_mem_qualified: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_o.mem_request_n |-> (ctrl_o.read_strobe_n ^ ctrl_o.store_strobe_n))
        else $error("memory request unqualified");
    a_mem_held_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(bus_hold_grant_n_o) |-> !req_oe_o && !addr_oe_o)
        else $error("memory request driven at grant");
    a_read_held_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        held_o |-> !ctrl_oe_o)
        else $error("read strobe driven while held");
    a_store_held_rel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !bus_hold_grant_n_o |-> !ctrl_oe_o && !data_oe_o)
        else $error("store strobe driven while held");
    a_fetch_with_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_o.fetch_indicator_n |-> (!ctrl_o.mem_request_n && !ctrl_o.read_strobe_n))
        else $error("fetch without memory read");
    a_wait_stretch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (in_access && !wait_s2_r) |=> (in_access && !done_o))
        else $error("access ended while waiting");
    a_grant_after_req: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ((state_r == EMB_ST_IDLE) && !hreq_s2_r) |=> ##1 !bus_hold_grant_n_o)
        else $error("grant not given after request");
    a_wait_done: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (in_access && wait_s2_r && acc_full) |=> (done_o && state_r == EMB_ST_FINISH))
        else $error("access not closed on wait high");

    c_write: cover property (@(posedge clk_i) disable iff (!arst_n_i) data_oe_o ##1 done_o);
    c_waited: cover property (@(posedge clk_i) disable iff (!arst_n_i) in_access && !wait_s2_r ##3 done_o);
    c_fetch: cover property (@(posedge clk_i) disable iff (!arst_n_i) !ctrl_o.fetch_indicator_n);
    c_hold: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(bus_hold_grant_n_o));

endmodule
`default_nettype wire

// [sim/emb_ext_mem.sv]
// Far-side memory and peripheral model for the bus master.
`timescale 1ns/100ps
`default_nettype none
module emb_ext_mem
    import emb_pkg::*;
(
    input  wire logic              clk_i,
    input  wire emb_ctrl_t         ctrl_i,
    input  wire logic              ctrl_oe_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wdata_oe_i,
    input  wire logic              stall_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   wait_n_o
);
    logic [DATA_W-1:0] mem_r [16];
    logic [DATA_W-1:0] last_r = 8'h00;
    logic              sel;
    logic              rd;
    assign sel = ctrl_oe_i && !(ctrl_i.mem_request_n && ctrl_i.io_request_n);
    assign rd  = sel && !ctrl_i.read_strobe_n;
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem_r[i] = 8'hA5 ^ 8'(i);
    end
    assign wait_n_o = !stall_i;
    // Released bus shows inverted data so a late sample never matches
    assign rdata_o = rd ? mem_r[addr_i[3:0]] : ~last_r;
    always @(posedge clk_i)
    begin
        if (rd)
            last_r <= mem_r[addr_i[3:0]];
        if (sel && !ctrl_i.store_strobe_n && wdata_oe_i)
            mem_r[addr_i[3:0]] <= wdata_i;
    end
endmodule
`default_nettype wire

// [sim/emb_bus_master_bench.sv]
// Self-checking bench for the external memory and I/O bus master.
`timescale 1ns/100ps
`default_nettype none
module emb_bus_master_bench
    import emb_pkg::*;
;
    typedef struct packed
    {
        emb_ctrl_t         ctrl;
        logic              oe;
        logic [DATA_W-1:0] rd;
        logic              chk;
    } emb_exp_t;
    logic              clk_i = 1'h0;
    logic              arst_n_i, req_valid_i, stall, hold_n, ext_mem_request_n_n;
    logic              req_ready_o, done_o, held_o, addr_oe_o, data_oe_o;
    logic              ctrl_oe_o, req_oe_o, bus_hold_grant_n_o, wait_n_i;
    logic              mem_request_n_i, io_request_n_i;
    logic [ADDR_W-1:0] ext_addr_i_o, addr_o, addr_i, ext_addr;
    logic [DATA_W-1:0] rdata_o, data_o, data_i, bus_rd;
    logic [DATA_W-1:0] shadow [16];
    emb_req_t          req_i;
    emb_ctrl_t         ctrl_o;
    emb_exp_t          exq [$];
    emb_exp_t          mon_e;
    int                seed = 32'hF159;
    int                mismatches = 0;
    int                check_count = 0;
    ////////////////////////////////////////////////////////////
    always #4 clk_i = ~clk_i;
    assign data_i          = data_oe_o ? data_o : bus_rd;
    assign mem_request_n_i = req_oe_o ? ctrl_o.mem_request_n : ext_mem_request_n_n;
    assign io_request_n_i  = req_oe_o ? ctrl_o.io_request_n : 1'h1;
    assign addr_i          = addr_oe_o ? addr_o : ext_addr;
    emb_bus_master dut_u (.clk_i, .arst_n_i, .req_valid_i, .req_i, .req_ready_o, .done_o, .rdata_o,
        .held_o, .ext_addr_i_o, .wait_n_i, .bus_hold_request_n_i(hold_n), .bus_hold_grant_n_o,
        .addr_o, .addr_oe_o, .data_i, .data_o, .data_oe_o, .mem_request_n_i, .io_request_n_i,
        .addr_i, .ctrl_o, .ctrl_oe_o, .req_oe_o);
    emb_ext_mem ext_u (.clk_i, .ctrl_i(ctrl_o), .ctrl_oe_i(ctrl_oe_o), .addr_i(addr_o), .wdata_i(data_o),
        .wdata_oe_i(data_oe_o), .stall_i(stall), .rdata_o(bus_rd), .wait_n_o(wait_n_i));
    ////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_rst();
        cmp({addr_oe_o, data_oe_o, ctrl_oe_o, req_oe_o, bus_hold_grant_n_o, done_o, held_o, req_ready_o}, 8'h08);
        cmp(ctrl_o, 5'h1F);
    endtask
    task automatic access(input emb_kind_t k, input logic io, input logic [3:0] a, input logic st);
        emb_exp_t e;
        int       n;
        req_i = '{{20'($random(seed)), a}, 8'($random(seed)), k, io};
        e.ctrl = '{io, !io, k == EMB_KIND_WRITE, k != EMB_KIND_WRITE, k != EMB_KIND_FETCH};
        e.oe = (k == EMB_KIND_WRITE);
        e.rd = shadow[a];
        e.chk = !e.oe;
        if (e.oe)
            shadow[a] = req_i.wdata;
        exq.push_back(e);
        stall = st;
        req_valid_i = 1'h1;
        n = 0;
        if (st)
        begin
            repeat (12)
            begin
                tick();
                cmp(done_o, 1'h0);
            end
            stall = 1'h0;
        end
        do
        begin
            tick();
            n++;
        end
        while (done_o !== 1'h1 && n < 40);
        cmp(n, st ? 3 : ACC_MIN_CYC + 2);
        req_valid_i = 1'h0;
        tick();
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge clk_i)
    begin
        if (done_o === 1'h1)
        begin
            cmp(exq.size() > 0, 1'h1);
            mon_e = exq.pop_front();
            cmp(ctrl_o, mon_e.ctrl);
            cmp(data_oe_o, mon_e.oe);
            if (mon_e.chk)
                cmp(rdata_o, mon_e.rd);
        end
    end
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
    initial
    begin
        arst_n_i = 1'h0;
        req_valid_i = 1'h0;
        req_i = '0;
        stall = 1'h0;
        hold_n = 1'h1;
        ext_mem_request_n_n = 1'h1;
        ext_addr = '0;
        for (int i = 0; i < 16; i++)
            shadow[i] = 8'hA5 ^ 8'(i);
        repeat (12) tick();
        chk_rst();
        arst_n_i = 1'h1;
        repeat (2) tick();
        for (int i = 0; i < 40; i++)
            access(emb_kind_t'(i % 3), (i % 3 != 2) & 1'($random(seed)), 4'($random(seed)), (i % 5) == 4);
        hold_n = 1'h0;
        repeat (6) tick();
        cmp({addr_oe_o, data_oe_o, ctrl_oe_o, req_oe_o, bus_hold_grant_n_o, held_o}, 6'h01);
        req_valid_i = 1'h1;
        ext_mem_request_n_n = 1'h0;
        ext_addr = 24'($random(seed));
        repeat (4) tick();
        cmp(ext_addr_i_o, ext_addr);
        cmp({ctrl_oe_o, req_oe_o, done_o, req_ready_o}, 4'h0);
        req_valid_i = 1'h0;
        ext_mem_request_n_n = 1'h1;
        hold_n = 1'h1;
        repeat (6) tick();
        cmp({addr_oe_o, data_oe_o, ctrl_oe_o, req_oe_o, bus_hold_grant_n_o, held_o, req_ready_o}, 7'h5D);
        // reset source keeps reset low three clocks
        arst_n_i = 1'h0;
        repeat (3) tick();
        chk_rst();
        arst_n_i = 1'h1;
        repeat (2) tick();
        access(EMB_KIND_FETCH, 1'h0, 4'h3, 1'h1);
        repeat (4) tick();
        results();
    end
endmodule
`default_nettype wire
